// file: tcl_map.svh
// offsets, field positions, reset values and timing counts of the torque loop
`ifndef TCL_MAP_SVH
`define TCL_MAP_SVH
// register byte offsets
`define TCL_OFS_CTRL 8'h00
`define TCL_OFS_NORM_CMD 8'h04
`define TCL_OFS_NM_CMD 8'h08
`define TCL_OFS_IQ_CMD 8'h0c
`define TCL_OFS_ID_CMD 8'h10
`define TCL_OFS_AMPS_LIM 8'h14
`define TCL_OFS_IQ_LIM 8'h18
`define TCL_OFS_TNM 8'h1c
`define TCL_OFS_TKP 8'h20
`define TCL_OFS_TKI 8'h24
`define TCL_OFS_TKD 8'h28
`define TCL_OFS_SKP 8'h2c
`define TCL_OFS_SKI 8'h30
`define TCL_OFS_SKD 8'h34
`define TCL_OFS_SPD_LIM 8'h38
`define TCL_OFS_STATUS 8'h3c
`define TCL_OFS_INT_ST 8'h40
`define TCL_OFS_INT_MASK 8'h44
`define TCL_OFS_AMPS 8'h48
`define TCL_OFS_DRIVE 8'h4c
`define TCL_OFS_LERR 8'h50
// control register fields
`define TCL_CTRL_EN 0
`define TCL_CTRL_BL 1
`define TCL_CTRL_SIN 2
`define TCL_CTRL_LVL_LO 3
`define TCL_CTRL_OVR 5
`define TCL_CTRL_SRC_LO 6
`define TCL_CTRL_KIND_LO 8
`define TCL_CTRL_EST 10
`define TCL_CTRL_W 11
// interrupt bits
`define TCL_IRQ_FAULT 0
`define TCL_IRQ_OVR 1
`define TCL_IRQ_EST 2
`define TCL_IRQ_W 3
// reset values: loop error level 1 enabled by default, gains P=0 I=1 D=0
`define TCL_RST_CTRL 11'h008
`define TCL_RST_LIM 16'h03e8
`define TCL_RST_TKI 16'h0001
`define TCL_RST_TNM 16'h0064
// command span and output span, both +/-1000
`define TCL_CMD_MAX 1000
`define TCL_EST_MIN 200
// sensing full range in amps*10 and its 0.5 percent step
`define TCL_SENSE_RANGE 3000
`define TCL_SENSE_STEP (`TCL_SENSE_RANGE / 200)
// integrator clamp, gains are 8.8 fixed point
`define TCL_GAIN_SHIFT 8
`define TCL_INT_MAX (`TCL_CMD_MAX * 256)
// timing
`define TCL_CLK_PERIOD_NS 20
`define TCL_CTRL_PERIOD_NS 1000000
`define TCL_LERR1_MS 250
`define TCL_LERR2_MS 500
`define TCL_LERR3_MS 1000
`define TCL_LERR1_TICKS (`TCL_LERR1_MS * 1000000 / `TCL_CTRL_PERIOD_NS)
`define TCL_LERR2_TICKS (`TCL_LERR2_MS * 1000000 / `TCL_CTRL_PERIOD_NS)
`define TCL_LERR3_TICKS (`TCL_LERR3_MS * 1000000 / `TCL_CTRL_PERIOD_NS)
`define TCL_LERR1_MAG 100
`define TCL_LERR2_MAG 250
`define TCL_LERR3_MAG 500
`endif

// file: tcl_pkg.sv
// types of the torque loop
package tcl_pkg;
  `include "tcl_map.svh"

  typedef enum logic [1:0] {
    TCL_KIND_NORM = 2'b00,
    TCL_KIND_NM = 2'b01,
    TCL_KIND_IQ = 2'b10,
    TCL_KIND_RSV = 2'b11
  } tcl_kind_t;

  typedef enum logic [1:0] {
    TCL_SRC_SERIAL = 2'b00,
    TCL_SRC_ANALOG = 2'b01,
    TCL_SRC_PULSE = 2'b10,
    TCL_SRC_RSV = 2'b11
  } tcl_src_t;

  typedef struct packed {
    logic [`TCL_CTRL_W-1:0] ctrl;
    logic signed [15:0] norm_cmd;
    logic signed [15:0] nm_cmd;
    logic signed [15:0] iq_cmd;
    logic signed [15:0] id_cmd;
    logic [15:0] amps_lim;
    logic [15:0] iq_lim;
    logic [15:0] motor_torque_constant;
    logic [15:0] tkp;
    logic [15:0] tki;
    logic [15:0] tkd;
    logic [15:0] skp;
    logic [15:0] ski;
    logic [15:0] skd;
    logic [15:0] spd_lim;
    logic [`TCL_IRQ_W-1:0] int_st;
    logic [`TCL_IRQ_W-1:0] int_mask;
    logic [15:0] cnt;
    logic tick;
    logic signed [15:0] iq_tgt;
    logic signed [15:0] id_tgt;
    logic signed [15:0] amps;
    logic signed [15:0] lerr;
    logic signed [31:0] q_int;
    logic signed [31:0] d_int;
    logic signed [31:0] s_int;
    logic signed [15:0] q_prev;
    logic signed [15:0] d_prev;
    logic signed [15:0] s_prev;
    logic signed [15:0] drive_q;
    logic signed [15:0] drive_d;
    logic [9:0] err_cnt;
    logic fault;
    logic ovr;
    logic est_low;
    logic power_en;
    logic irq;
    logic [31:0] rdata;
  } tcl_state_t;
endpackage

// file: tcl_pid.sv
// one step of a pid with clamped output and anti-windup integrator
`include "tcl_map.svh"
module tcl_pid (
  input logic signed [15:0] err, // present error
  input logic signed [15:0] prev_err, // error of the previous step
  input logic signed [31:0] int_in, // integrator before the step
  input logic [15:0] kp, // proportional gain, 8.8
  input logic [15:0] ki, // integral gain, 8.8
  input logic [15:0] kd, // derivative gain, 8.8
  output logic signed [15:0] out, // output clamped to +/-1000
  output logic signed [31:0] int_out // integrator after the step
);
  import tcl_pkg::*;

  localparam logic signed [31:0] INT_MAX = 32'(`TCL_INT_MAX);
  localparam logic signed [31:0] OUT_MAX = 32'(`TCL_CMD_MAX);

  // saturate a wide value to +/-lim
  function automatic logic signed [31:0] clamp32(input logic signed [31:0] v,
                                                 input logic signed [31:0] lim);
    if (v > lim) begin
      clamp32 = lim;
    end else if (v < -lim) begin
      clamp32 = -lim;
    end else begin
      clamp32 = v;
    end
  endfunction

  logic signed [31:0] p_term;
  logic signed [31:0] d_term;
  logic signed [31:0] i_sum;
  logic signed [31:0] total;

  // gains are unsigned, widened with a zero sign bit
  always_comb begin
    p_term = 32'(err) * $signed({16'h0000, kp});
    d_term = 32'(32'(err) - 32'(prev_err)) * $signed({16'h0000, kd});
    i_sum = clamp32(int_in + 32'(err) * $signed({16'h0000, ki}), INT_MAX);
    total = clamp32((p_term + d_term + i_sum) >>> `TCL_GAIN_SHIFT, OUT_MAX);
    int_out = i_sum;
    out = total[15:0];
  end
endmodule // tcl_pid

// file: tcl_torque_loop.sv
// closed-loop torque controller for one motor channel, with register port
`include "tcl_map.svh"
import tcl_pkg::*;

// What this block does
// - Command sets motor current target regardless of actual speed.
// - Normalized command +/-1000 scaled by amps limit on brushed channels.
// - Brushless sinusoidal scales normalized command by quadrature amps limit.
// - Newton-metre command converted to current with motor torque constant.
// - Direct quadrature current command in amps*10, brushless sinusoidal only.
// - Direct flux current command in amps*10, brushless sinusoidal only.
// - Command taken from serial, analog or pulse source as current command.
// - Measured motor current is loop feedback, same pid as other modes.
// - Brushless runs PI only on torque gains; field-oriented (flux loop) on brushless sinusoidal only.
// - Zero command drives zero current; negative command gives braking current.
// - Cut power when loop error stays large too long; can be disabled.
// - Brushless speed limit by speed pid override with its own gains.
// - Estimated current valid from 20% output; zero at 0% output.
// - Current measurement resolution about 0.5% of full range.
// - Error levels: >100 for 250ms, >250 for 500ms, >500 for 1000ms.
module tcl_torque_loop #(
  parameter int unsigned PERIOD_CYC = `TCL_CTRL_PERIOD_NS / `TCL_CLK_PERIOD_NS
) (
  input wire logic clk, // 50 MHz clock
  input wire logic nrst, // asynchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // register write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic signed [15:0] meas_amps, // measured motor current, amps*10
  input wire logic signed [15:0] batt_amps, // measured battery current, amps*10
  input wire logic signed [15:0] speed, // measured speed
  input wire logic signed [15:0] analog_cmd, // analog input command, +/-1000
  input wire logic signed [15:0] pulse_cmd, // pulse input command, +/-1000
  output logic [31:0] rdata, // read data, cycle after rd
  output logic signed [15:0] drive_q, // quadrature or brushed drive, +/-1000
  output logic signed [15:0] drive_d, // flux drive, +/-1000
  output logic power_en, // power stage enable
  output logic irq // level interrupt
);
  import tcl_pkg::*;

  localparam logic signed [31:0] CMAX = 32'(`TCL_CMD_MAX);

  function automatic logic signed [15:0] sat16(input logic signed [31:0] v,
                                               input logic signed [31:0] lim);
    if (v > lim) begin
      sat16 = lim[15:0];
    end else if (v < -lim) begin
      sat16 = 16'(-lim);
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  // a*b/c with a zero divisor giving zero
  function automatic logic signed [31:0] muldiv(input logic signed [31:0] a,
                                                input logic signed [31:0] b,
                                                input logic signed [31:0] c);
    muldiv = (c == 32'sh0) ? 32'sh0 : (a * b) / c;
  endfunction

  function automatic logic signed [31:0] mag(input logic signed [15:0] v);
    mag = (v < 16'sh0) ? -32'(v) : 32'(v);
  endfunction

  tcl_state_t s_r, s_nxt;
  logic signed [15:0] q_out, d_out, sp_out;
  logic signed [31:0] q_int_o, d_int_o, s_int_o;
  logic signed [15:0] q_err, d_err, s_err;
  logic bl, sinus, bl_sin;
  tcl_kind_t kind;
  tcl_src_t src;
  logic signed [15:0] norm_sel;
  logic signed [31:0] tgt_raw;
  logic signed [31:0] amps_raw;
  logic signed [31:0] over;
  logic signed [31:0] lim_sel;
  logic [1:0] lvl;
  logic big_err;
  logic [9:0] err_ticks;
  logic [`TCL_IRQ_W-1:0] ev;

  assign bl = s_r.ctrl[`TCL_CTRL_BL];
  assign sinus = s_r.ctrl[`TCL_CTRL_SIN];
  assign bl_sin = bl & sinus;
  assign kind = tcl_kind_t'(s_r.ctrl[`TCL_CTRL_KIND_LO +: 2]);
  assign src = tcl_src_t'(s_r.ctrl[`TCL_CTRL_SRC_LO +: 2]);
  assign lvl = s_r.ctrl[`TCL_CTRL_LVL_LO +: 2];
  assign q_err = s_r.lerr;
  assign d_err = sat16(32'(s_r.id_tgt), CMAX);
  assign over = mag(speed) - 32'(s_r.spd_lim);
  assign s_err = sat16(over, CMAX);

  // torque or brushed loop: brushless runs the PI only
  tcl_pid u_q (
    .err(q_err),
    .prev_err(s_r.q_prev),
    .int_in(s_r.q_int),
    .kp(s_r.tkp),
    .ki(s_r.tki),
    .kd(bl ? 16'h0000 : s_r.tkd),
    .out(q_out),
    .int_out(q_int_o)
  );

  // flux loop, same torque gains; the flux current is not measured here
  tcl_pid u_d (
    .err(d_err),
    .prev_err(s_r.d_prev),
    .int_in(s_r.d_int),
    .kp(s_r.tkp),
    .ki(s_r.tki),
    .kd(16'h0000),
    .out(d_out),
    .int_out(d_int_o)
  );

  // speed override loop with its own gains
  tcl_pid u_s (
    .err(s_err),
    .prev_err(s_r.s_prev),
    .int_in(s_r.s_int),
    .kp(s_r.skp),
    .ki(s_r.ski),
    .kd(s_r.skd),
    .out(sp_out),
    .int_out(s_int_o)
  );

  // next state: register port, targets, feedback, loop step, protection
  always_comb begin
    s_nxt = s_r;
    ev = '0;
    norm_sel = s_r.norm_cmd;
    tgt_raw = 32'sh0;
    amps_raw = 32'sh0;
    lim_sel = 32'sh0;
    err_ticks = 10'(`TCL_LERR1_TICKS);
    big_err = 1'b0;
    // control period counter
    // fixed control period
    s_nxt.tick = (s_r.cnt == 16'(PERIOD_CYC - 1));
    s_nxt.cnt = s_nxt.tick ? 16'h0000 : 16'(s_r.cnt + 16'h0001);
    case (src)
      TCL_SRC_ANALOG: norm_sel = analog_cmd;
      TCL_SRC_PULSE: norm_sel = pulse_cmd;
      default: norm_sel = s_r.norm_cmd;
    endcase
    norm_sel = sat16(32'(norm_sel), CMAX);
    lim_sel = bl_sin ? 32'(s_r.iq_lim) : 32'(s_r.amps_lim);
    // target current from command only, sign kept
    case (kind)
      TCL_KIND_NM: tgt_raw = muldiv(32'(s_r.nm_cmd), 32'sd100, 32'(s_r.motor_torque_constant));
      TCL_KIND_IQ: tgt_raw = bl_sin ? 32'(s_r.iq_cmd) : 32'sh0;
      default: tgt_raw = muldiv(32'(norm_sel), lim_sel, CMAX);
    endcase
    // speed override pulls the target toward zero
    s_nxt.ovr = bl & s_r.ctrl[`TCL_CTRL_OVR] & (over > 32'sh0);
    if (s_r.ovr && sp_out > 16'sh0) begin
      tgt_raw = tgt_raw - muldiv(tgt_raw, 32'(sp_out), CMAX);
    end
    s_nxt.iq_tgt = sat16(tgt_raw, 32'sd32767);
    // flux target only on brushless sinusoidal
    s_nxt.id_tgt = bl_sin ? s_r.id_cmd : 16'sh0;
    // estimate from battery current at the present output
    if (s_r.ctrl[`TCL_CTRL_EST]) begin
      amps_raw = (s_r.drive_q == 16'sh0) ? 32'sh0 :
                 muldiv(32'(batt_amps), CMAX, 32'(s_r.drive_q));
    end else begin
      amps_raw = 32'(meas_amps);
    end
    s_nxt.est_low = s_r.ctrl[`TCL_CTRL_EST] && mag(s_r.drive_q) < 32'(`TCL_EST_MIN);
    // saturate first, then quantize, so a clipped value stays on the step
    amps_raw = 32'(sat16(amps_raw, 32'sd32767));
    amps_raw = (amps_raw / 32'(`TCL_SENSE_STEP)) * 32'(`TCL_SENSE_STEP);
    s_nxt.amps = amps_raw[15:0];
    // loop error is target minus measured
    s_nxt.lerr = sat16(32'(s_r.iq_tgt) - 32'(s_r.amps), 32'sd32767);
    case (lvl)
      2'b01: begin
        big_err = mag(s_r.lerr) > 32'(`TCL_LERR1_MAG);
        err_ticks = 10'(`TCL_LERR1_TICKS);
      end
      2'b10: begin
        big_err = mag(s_r.lerr) > 32'(`TCL_LERR2_MAG);
        err_ticks = 10'(`TCL_LERR2_TICKS);
      end
      2'b11: begin
        big_err = mag(s_r.lerr) > 32'(`TCL_LERR3_MAG);
        err_ticks = 10'(`TCL_LERR3_TICKS);
      end
      default: begin
        big_err = 1'b0;
        err_ticks = 10'(`TCL_LERR1_TICKS);
      end
    endcase
    // loop step once per period
    if (s_r.tick) begin
      // error duration count, level 0 disables
      if (big_err && s_r.ctrl[`TCL_CTRL_EN]) begin
        s_nxt.err_cnt = 10'(s_r.err_cnt + 10'h001);
        if (s_nxt.err_cnt >= err_ticks) begin
          s_nxt.fault = 1'b1;
        end
      end else begin
        s_nxt.err_cnt = 10'h000;
      end
      // pi or pid step, output clamped to +/-1000
      s_nxt.drive_q = q_out;
      s_nxt.q_int = q_int_o;
      s_nxt.q_prev = q_err;
      s_nxt.drive_d = bl_sin ? d_out : 16'sh0;
      s_nxt.d_int = bl_sin ? d_int_o : 32'sh0;
      s_nxt.d_prev = bl_sin ? d_err : 16'sh0;
      s_nxt.s_int = s_r.ovr ? s_int_o : 32'sh0;
      s_nxt.s_prev = s_r.ovr ? s_err : 16'sh0;
    end
    // disabled or faulted channel: no drive, integrators cleared
    if (!s_r.ctrl[`TCL_CTRL_EN] || s_r.fault) begin
      s_nxt.drive_q = 16'sh0;
      s_nxt.drive_d = 16'sh0;
      s_nxt.q_int = 32'sh0;
      s_nxt.d_int = 32'sh0;
      s_nxt.s_int = 32'sh0;
    end
    // events for sticky status
    ev[`TCL_IRQ_FAULT] = s_nxt.fault & ~s_r.fault;
    ev[`TCL_IRQ_OVR] = s_nxt.ovr & ~s_r.ovr;
    ev[`TCL_IRQ_EST] = s_nxt.est_low & ~s_r.est_low;
    // register port
    s_nxt.rdata = 32'h0000_0000;
    if (wr) begin
      if (addr == `TCL_OFS_CTRL) begin
        s_nxt.ctrl = wdata[`TCL_CTRL_W-1:0];
        if (!wdata[`TCL_CTRL_EN]) begin
          s_nxt.fault = 1'b0; // fault clears when the channel is disabled
          s_nxt.err_cnt = 10'h000;
        end
      end else if (addr == `TCL_OFS_NORM_CMD) begin
        s_nxt.norm_cmd = wdata[15:0];
      end else if (addr == `TCL_OFS_NM_CMD) begin
        s_nxt.nm_cmd = wdata[15:0];
      end else if (addr == `TCL_OFS_IQ_CMD) begin
        s_nxt.iq_cmd = wdata[15:0];
      end else if (addr == `TCL_OFS_ID_CMD) begin
        s_nxt.id_cmd = wdata[15:0];
      end else if (addr == `TCL_OFS_AMPS_LIM) begin
        s_nxt.amps_lim = wdata[15:0];
      end else if (addr == `TCL_OFS_IQ_LIM) begin
        s_nxt.iq_lim = wdata[15:0];
      end else if (addr == `TCL_OFS_TNM) begin
        s_nxt.motor_torque_constant = wdata[15:0];
      end else if (addr == `TCL_OFS_TKP) begin
        s_nxt.tkp = wdata[15:0];
      end else if (addr == `TCL_OFS_TKI) begin
        s_nxt.tki = wdata[15:0];
      end else if (addr == `TCL_OFS_TKD) begin
        s_nxt.tkd = wdata[15:0];
      end else if (addr == `TCL_OFS_SKP) begin
        s_nxt.skp = wdata[15:0];
      end else if (addr == `TCL_OFS_SKI) begin
        s_nxt.ski = wdata[15:0];
      end else if (addr == `TCL_OFS_SKD) begin
        s_nxt.skd = wdata[15:0];
      end else if (addr == `TCL_OFS_SPD_LIM) begin
        s_nxt.spd_lim = wdata[15:0];
      end else if (addr == `TCL_OFS_INT_MASK) begin
        s_nxt.int_mask = wdata[`TCL_IRQ_W-1:0];
      end
    end
    // power follows the new enable, so disabling to clear a fault never pulses it
    s_nxt.power_en = s_nxt.ctrl[`TCL_CTRL_EN] & ~s_nxt.fault;
    // sticky status: write one clears, a new event wins
    if (wr && addr == `TCL_OFS_INT_ST) begin
      s_nxt.int_st = (s_r.int_st & ~wdata[`TCL_IRQ_W-1:0]) | ev;
    end else begin
      s_nxt.int_st = s_r.int_st | ev;
    end
    s_nxt.irq = |(s_nxt.int_st & s_nxt.int_mask);
    if (rd) begin
      if (addr == `TCL_OFS_CTRL) begin
        s_nxt.rdata = 32'(s_r.ctrl);
      end else if (addr == `TCL_OFS_NORM_CMD) begin
        s_nxt.rdata = 32'(s_r.norm_cmd);
      end else if (addr == `TCL_OFS_NM_CMD) begin
        s_nxt.rdata = 32'(s_r.nm_cmd);
      end else if (addr == `TCL_OFS_IQ_CMD) begin
        s_nxt.rdata = 32'(s_r.iq_cmd);
      end else if (addr == `TCL_OFS_ID_CMD) begin
        s_nxt.rdata = 32'(s_r.id_cmd);
      end else if (addr == `TCL_OFS_AMPS_LIM) begin
        s_nxt.rdata = {16'h0000, s_r.amps_lim};
      end else if (addr == `TCL_OFS_IQ_LIM) begin
        s_nxt.rdata = {16'h0000, s_r.iq_lim};
      end else if (addr == `TCL_OFS_TNM) begin
        s_nxt.rdata = {16'h0000, s_r.motor_torque_constant};
      end else if (addr == `TCL_OFS_TKP) begin
        s_nxt.rdata = {16'h0000, s_r.tkp};
      end else if (addr == `TCL_OFS_TKI) begin
        s_nxt.rdata = {16'h0000, s_r.tki};
      end else if (addr == `TCL_OFS_TKD) begin
        s_nxt.rdata = {16'h0000, s_r.tkd};
      end else if (addr == `TCL_OFS_SKP) begin
        s_nxt.rdata = {16'h0000, s_r.skp};
      end else if (addr == `TCL_OFS_SKI) begin
        s_nxt.rdata = {16'h0000, s_r.ski};
      end else if (addr == `TCL_OFS_SKD) begin
        s_nxt.rdata = {16'h0000, s_r.skd};
      end else if (addr == `TCL_OFS_SPD_LIM) begin
        s_nxt.rdata = {16'h0000, s_r.spd_lim};
      end else if (addr == `TCL_OFS_STATUS) begin
        s_nxt.rdata = {28'h0, s_r.est_low, s_r.ovr, s_r.power_en, s_r.fault};
      end else if (addr == `TCL_OFS_INT_ST) begin
        s_nxt.rdata = 32'(s_r.int_st);
      end else if (addr == `TCL_OFS_INT_MASK) begin
        s_nxt.rdata = 32'(s_r.int_mask);
      end else if (addr == `TCL_OFS_AMPS) begin
        s_nxt.rdata = 32'(s_r.amps);
      end else if (addr == `TCL_OFS_DRIVE) begin
        s_nxt.rdata = {s_r.drive_d, s_r.drive_q};
      end else if (addr == `TCL_OFS_LERR) begin
        s_nxt.rdata = 32'(s_r.lerr);
      end
    end
  end

  // state register with clock enable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.ctrl <= `TCL_RST_CTRL;
      s_r.amps_lim <= `TCL_RST_LIM;
      s_r.iq_lim <= `TCL_RST_LIM;
      s_r.motor_torque_constant <= `TCL_RST_TNM;
      s_r.tki <= `TCL_RST_TKI; // tuning starts from I=1
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign drive_q = s_r.drive_q;
  assign drive_d = s_r.drive_d;
  assign power_en = s_r.power_en;
  assign irq = s_r.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence fault_seen_s;
    s_r.fault && ce;
  endsequence

  sequence drive_off_s;
    drive_q == 16'sh0 && drive_d == 16'sh0 && !power_en;
  endsequence

  drive_range_a: assert property (mag(drive_q) <= CMAX && mag(drive_d) <= CMAX)
    else $error("drive outside +/-1000");
  fault_off_a: assert property (fault_seen_s |=> drive_off_s)
    else $error("drive not cut after fault");
  lvl_off_a: assert property (ce && lvl == 2'b00 && !s_r.fault |=> !s_r.fault)
    else $error("fault with detection disabled");
  tick_gap_a: assert property (s_r.tick && ce |=> !s_r.tick)
    else $error("two loop steps in a row");
  flux_zero_a: assert property (ce && !bl_sin |=> s_r.id_tgt == 16'sh0)
    else $error("flux target off brushless sinusoidal");
  est_zero_a: assert property (ce && s_r.ctrl[`TCL_CTRL_EST] && s_r.drive_q == 16'sh0
                               |=> s_r.amps == 16'sh0)
    else $error("current reported at zero output");
  amps_step_a: assert property (32'(s_r.amps) % 32'(`TCL_SENSE_STEP) == 32'sh0)
    else $error("current not on sensing step");
  norm_scale_a: assert property (ce && kind == TCL_KIND_NORM && !s_r.ovr && src == TCL_SRC_SERIAL
                                 && $stable(s_r.norm_cmd) && $stable(lim_sel)
                                 |=> mag(s_r.iq_tgt) <= $past(lim_sel))
    else $error("normalized target above limit");
  irq_map_a: assert property (irq == |(s_r.int_st & s_r.int_mask))
    else $error("interrupt not matching status and mask");
  zero_cmd_a: assert property (ce && kind == TCL_KIND_NORM && src == TCL_SRC_SERIAL
                               && s_r.norm_cmd == 16'sh0 |=> s_r.iq_tgt == 16'sh0)
    else $error("zero command gives nonzero target");
endmodule // tcl_torque_loop

// file: tcl_motor_model.sv
// behavioural power stage with lagging, quantised current sensing
module tcl_motor_model (
  input wire logic clk, // control clock
  input wire logic nrst, // async reset, active low
  input wire logic signed [15:0] drive_q, // drive, +/-1000
  output logic signed [15:0] meas_amps // sensed current, amps*10
);
  timeunit 1ns;
  timeprecision 1ns;
  logic signed [15:0] raw_r;
  // lightly loaded motor: current lags and tops out far below target
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      raw_r <= 16'sh0000;
    end else begin
      raw_r <= raw_r + (drive_q / 16'sd20 - raw_r) / 16'sd4;
    end
  end
  assign meas_amps = (raw_r / 16'sd15) * 16'sd15;
endmodule // tcl_motor_model

// file: tcl_torque_loop_bench.sv
// self-checking bench of the torque loop beside a power stage model
`include "tcl_map.svh"
module tcl_torque_loop_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import tcl_pkg::*;
  localparam int PER = 8;
  logic clk, nrst, ce, wr, rd, irq, power_en;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, got;
  logic signed [15:0] meas_amps, analog_cmd, drive_q, drive_d;
  int fail_count, comparisons, n;
  tcl_torque_loop #(.PERIOD_CYC(PER)) uut (.clk(clk), .nrst(nrst), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .meas_amps(meas_amps),
    .batt_amps(16'sh0000), .speed(16'sh0000), .analog_cmd(analog_cmd),
    .pulse_cmd(16'sh0000), .rdata(rdata), .drive_q(drive_q), .drive_d(drive_d),
    .power_en(power_en), .irq(irq));
  tcl_motor_model motor (.clk(clk), .nrst(nrst), .drive_q(drive_q),
    .meas_amps(meas_amps));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // verdict and end of run
  task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data is caught in the single cycle it stands
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  // bounded wait for the power stage to be cut
  task automatic wait_trip();
    n = 0;
    while (power_en !== 1'b0 && n < 300 * PER) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300 * PER) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic check_resets();
    rd_reg(`TCL_OFS_CTRL);
    cmp("ctrl reset", 32'h008, got);
    rd_reg(`TCL_OFS_TKI);
    cmp("integral gain reset", 32'h001, got);
    rd_reg(`TCL_OFS_TNM);
    cmp("torque constant reset", 32'h064, got);
    wr_reg(8'hfc, 32'h0000ffff);
    rd_reg(8'hfc);
    cmp("unmapped read", 32'h0, got);
  endtask
  // loop error with the motor at rest equals the current target
  task automatic tgt(input logic [31:0] ctl, input logic [7:0] a, input logic [31:0] c,
      input logic [31:0] exp);
    wr_reg(`TCL_OFS_CTRL, ctl);
    wr_reg(a, c);
    repeat (3) @(posedge clk);
    rd_reg(`TCL_OFS_LERR);
    cmp("loop error", exp, got);
  endtask
  task automatic check_targets();
    wr_reg(`TCL_OFS_AMPS_LIM, 32'h0c8);
    tgt(32'h000, `TCL_OFS_NORM_CMD, 32'h1f4, 32'h064);
    tgt(32'h006, `TCL_OFS_NORM_CMD, 32'h1f4, 32'h1f4);
    tgt(32'h000, `TCL_OFS_NORM_CMD, 32'hfffffe0c, 32'hffffff9c);
    tgt(32'h100, `TCL_OFS_NM_CMD, 32'h12c, 32'h12c);
    tgt(32'h206, `TCL_OFS_IQ_CMD, 32'h04d, 32'h04d);
    tgt(32'h200, `TCL_OFS_IQ_CMD, 32'h04d, 32'h0);
    analog_cmd <= 16'sh012c;
    tgt(32'h040, `TCL_OFS_NORM_CMD, 32'h0, 32'h03c);
  endtask
  // large error trips after the level-one hold time; interrupt masked then shown
  task automatic check_trip();
    wr_reg(`TCL_OFS_INT_MASK, 32'h0);
    wr_reg(`TCL_OFS_NORM_CMD, 32'h0);
    wr_reg(`TCL_OFS_CTRL, 32'h009);
    repeat (3 * PER) @(posedge clk);
    cmp("power on", 32'h1, {31'h0, power_en});
    wr_reg(`TCL_OFS_NORM_CMD, 32'h3e8);
    wait_trip();
    cmp("trip time", 32'h1, {31'h0, n >= 249 * PER && n <= 252 * PER});
    repeat (2) @(posedge clk);
    cmp("masked irq", 32'h0, {31'h0, irq});
    rd_reg(`TCL_OFS_INT_ST);
    cmp("fault event", 32'h1, got);
    wr_reg(`TCL_OFS_INT_MASK, 32'h1);
    repeat (2) @(posedge clk);
    cmp("raised irq", 32'h1, {31'h0, irq});
    wr_reg(`TCL_OFS_INT_ST, 32'h1);
    repeat (2) @(posedge clk);
    cmp("cleared irq", 32'h0, {31'h0, irq});
  endtask
  // detection off: the same error never cuts power, drive pushes forward
  task automatic check_level_off();
    wr_reg(`TCL_OFS_CTRL, 32'h0);
    wr_reg(`TCL_OFS_CTRL, 32'h001);
    repeat (300 * PER) @(posedge clk);
    cmp("power kept", 32'h1, {31'h0, power_en});
    cmp("drive forward", 32'h1, {31'h0, drive_q > 16'sh0000});
    cmp("drive clamp", 32'h1, {31'h0, drive_q <= 16'sh03e8});
  endtask
  // flux drive only on brushless sinusoidal; clock enable low freezes the drives
  task automatic check_flux();
    wr_reg(`TCL_OFS_ID_CMD, 32'h064);
    repeat (4 * PER) @(posedge clk);
    cmp("flux off brushed", 32'h0, 32'(drive_d));
    wr_reg(`TCL_OFS_CTRL, 32'h007);
    repeat (8 * PER) @(posedge clk);
    cmp("flux drive", 32'h1, {31'h0, drive_d > 16'sh0000});
    ce <= 1'b0;
    @(posedge clk);
    got = {drive_d, drive_q};
    repeat (4 * PER) @(posedge clk);
    cmp("frozen drive", got, {drive_d, drive_q});
    ce <= 1'b1;
  endtask
  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    analog_cmd = 16'sh0000;
    fail_count = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    check_resets();
    check_targets();
    check_trip();
    check_level_off();
    check_flux();
    report_and_stop();
  end
endmodule // tcl_torque_loop_bench
